// ===== hdl/vpc_pkg.sv
/*
 * Types and constants of the capture front end:
 * modes, field selection, config and timer carriers,
 * code and transport constants, FIFO sizing.
 * Assumes the port, its checker and its bench import it.
 */
`default_nettype none

package vpc_pkg;

    // Capture modes
    typedef enum logic [3:0] {
        VPC_BT656_8,
        VPC_BT656_10,
        VPC_RAW_8,
        VPC_RAW_10,
        VPC_YC_8,
        VPC_YC_10,
        VPC_RAW_16,
        VPC_RAW_20,
        VPC_TS_8
    } vpc_mode_t;

    // Field selection
    typedef enum logic [1:0] {
        VPC_FSEL_ALL,
        VPC_FSEL_ODD,
        VPC_FSEL_EVEN,
        VPC_FSEL_SINGLE
    } vpc_fsel_t;

    // Transport states
    typedef enum logic [1:0] {
        VPC_TS_HUNT,
        VPC_TS_HDR1,
        VPC_TS_BODY
    } vpc_ts_state_t;

    localparam int VPC_BUS_W = 20;
    localparam int VPC_CH_W = 10;
    localparam int VPC_POS_W = 12;
    localparam int VPC_FIFO_W = 32;
    localparam int VPC_FIFO_DEPTH = 32;
    localparam int VPC_LVL_W = 6;
    localparam int VPC_NUM_FIFO = 6;
    localparam int VPC_PIN_W = 24;
    localparam int VPC_TIME_W = 32;

    typedef struct packed {
        vpc_mode_t mode;
        logic dual;
        logic chb_raw;
        logic big_endian;
        logic resample_req;
        logic scale_req;
        logic yc_ctl_sync;
        vpc_fsel_t fsel;
        logic [VPC_POS_W-1:0] win_start;
        logic [VPC_POS_W-1:0] win_stop;
        logic [VPC_POS_W-1:0] ts_pkt_len;
        logic ts_drop_err;
        logic [VPC_LVL_W-1:0] dma_thresh;
    } vpc_cfg_t;

    typedef struct packed {
        logic abs_en;
        logic [VPC_TIME_W-1:0] abs_time;
        logic intv_en;
        logic [VPC_TIME_W-1:0] intv;
    } vpc_timer_cfg_t;

    // Timing code and XY bit positions
    localparam logic [7:0] VPC_CODE_FF = 8'hFF;
    localparam logic [7:0] VPC_CODE_00 = 8'h00;
    localparam int VPC_XY_F = 8;
    localparam int VPC_XY_H = 6;
    // Transport packet header
    localparam logic [7:0] VPC_TS_SYNC = 8'h47;
    localparam logic [VPC_POS_W-1:0] VPC_TS_HDR_LEN = 12'h004;
    localparam int VPC_TS_ERR_BIT = 7;
    // Values after reset
    localparam logic [VPC_FIFO_W-1:0] VPC_WORD_RST = 32'h0000_0000;
    localparam logic [VPC_TIME_W-1:0] VPC_TIME_RST = 32'h0000_0000;
    localparam logic [VPC_POS_W-1:0] VPC_POS_RST = 12'h000;

endpackage

`default_nettype wire

// ===== hdl/vpc_sync3.sv
/*
 * Three-stage pin synchroniser, agreement filter.
 * Assumes async inputs; a level is taken only
 * when stages two and three agree, per bit.
 */
`default_nettype none

module vpc_sync3 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Pins and filtered levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] filt_q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] agree;
    logic [W-1:0] filt_d;

    // Stage one is read only by stage two
    assign agree = ~(s2_q ^ s3_q);
    assign filt_d = (s2_q & agree) | (filt_q & ~agree);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            filt_q <= '0;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= filt_d;
        end
    end
endmodule

`default_nettype wire

// ===== hdl/vpc_fifo.sv
/*
 * Synchronous FIFO, valid/ready both sides, fill level.
 * Assumes one clock; flush empties it at once.
 */
`default_nettype none

module vpc_fifo #(
    parameter int W = 32,
    parameter int DEPTH = 32
) (
    // Clock, reset, flush
    input wire logic clk,
    input wire logic resetn,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic wr_en;
    logic rd_en;

    assign level = wr_q - rd_q;
    assign in_ready = (level != DEPTH[AW:0]);
    assign out_valid = (level != '0);
    assign wr_en = in_valid & in_ready;
    assign rd_en = out_valid & out_ready;
    assign out_data = mem[rd_q[AW-1:0]];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn || flush) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_q + {{AW{1'b0}}, wr_en};
            rd_q <= rd_q + {{AW{1'b0}}, rd_en};
        end
    end
endmodule

`default_nettype wire

// ===== hdl/vpc_capture_port.sv
/*
 * Two-channel video capture front end:
 * BT.656, Y/C, raw and transport capture
 * into six packing FIFOs with DMA requests.
 * Assumes pins are async to clk and pin
 * clocks at most a quarter of its rate.
 */
`default_nettype none

// Function
// - Nine capture modes chosen by configuration
// - Raw words stored unchanged
// - BT.656 order Cb Y Cr Y
// - Components split into three FIFOs
// - Packing follows sample size and endianness
// - 8-bit components taken from bits 9:2
// - Dual: channel B as BT.656 or raw beside BT.656 or narrow raw A
// - Single channel captures channel A only
// - Filters only for 8-bit BT.656 and Y/C
// - Pixel window bounds capture per line
// - Even, odd, all or single field selection
// - Y/C uses both bus halves
// - Y/C syncs from codes or control pins
// - Ancillary data captured as ordinary samples
// - Raw ignores data values and filters
// - Narrow raw two streams, wide raw one
// - Transport sync detect, programmable length
// - Transport input is 8-bit parallel bytes
// - Four-byte header with error indicator
// - Packets stamped with system time
// - Errored packets optionally discarded
// - Time event at absolute or interval time
// - DMA request at FIFO threshold
module vpc_capture_port (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Capture pins
    input wire logic chan_a_capture_clock,
    input wire logic chan_b_capture_clock,
    input wire logic [vpc_pkg::VPC_BUS_W-1:0] port_pixel_bus,
    input wire logic ctl_line_active,
    input wire logic ctl_field,
    // Configuration
    input wire logic capture_enable,
    input wire vpc_pkg::vpc_cfg_t cfg,
    input wire vpc_pkg::vpc_timer_cfg_t tmr,
    // FIFO drain and DMA requests
    output logic [vpc_pkg::VPC_NUM_FIFO-1:0] rd_valid,
    input wire logic [vpc_pkg::VPC_NUM_FIFO-1:0] rd_ready,
    output logic [vpc_pkg::VPC_NUM_FIFO-1:0][vpc_pkg::VPC_FIFO_W-1:0] rd_data,
    output logic [vpc_pkg::VPC_NUM_FIFO-1:0] dma_req,
    // Status
    output logic [vpc_pkg::VPC_NUM_FIFO-1:0] overflow,
    output logic [1:0] field_done,
    output logic resample_active,
    output logic scale_active,
    output logic ts_locked,
    output logic [vpc_pkg::VPC_TIME_W-1:0] ts_stamp,
    output logic ts_stamp_valid,
    output logic ts_dropped,
    output logic time_event
);
    import vpc_pkg::*;

    // Pin sync and link clock edges
    logic [VPC_PIN_W-1:0] pin_raw;
    logic [VPC_PIN_W-1:0] pin_f;
    logic [VPC_BUS_W-1:0] bus_f;
    logic [1:0] lclk_f;
    logic [1:0] lclk_prev_q;
    logic ctl_la;
    logic ctl_fld;
    logic clr;

    assign pin_raw = {ctl_field, ctl_line_active, chan_b_capture_clock,
                      chan_a_capture_clock, port_pixel_bus};
    assign bus_f = pin_f[VPC_BUS_W-1:0];
    assign lclk_f = pin_f[21:20];
    assign ctl_la = pin_f[22];
    assign ctl_fld = pin_f[23];
    assign clr = ~resetn | ~capture_enable;

    vpc_sync3 #(.W(VPC_PIN_W)) u_pins (
        .clk(clk),
        .resetn(resetn),
        .d(pin_raw),
        .filt_q(pin_f)
    );

    always_ff @(posedge clk) begin
        if (!resetn) begin
            lclk_prev_q <= 2'h0;
        end else begin
            lclk_prev_q <= lclk_f;
        end
    end

    // Mode decode
    logic m_bt;
    logic m_rawn;
    logic m_yc;
    logic m_wide;
    logic m_ts;
    logic m_8b;
    logic b_en;
    logic [1:0] edge_s;
    logic [1:0] ch_bt;
    logic [1:0] ch_raw;
    logic [1:0] yc_on;
    logic [1:0][VPC_CH_W-1:0] samp;
    logic [1:0][VPC_BUS_W-1:0] comp;
    logic [1:0][VPC_BUS_W-1:0] rawv;

    assign m_bt = (cfg.mode == VPC_BT656_8) | (cfg.mode == VPC_BT656_10);
    assign m_rawn = (cfg.mode == VPC_RAW_8) | (cfg.mode == VPC_RAW_10);
    assign m_yc = (cfg.mode == VPC_YC_8) | (cfg.mode == VPC_YC_10);
    assign m_wide = (cfg.mode == VPC_RAW_16) | (cfg.mode == VPC_RAW_20);
    assign m_ts = (cfg.mode == VPC_TS_8);
    assign m_8b = (cfg.mode == VPC_BT656_8) | (cfg.mode == VPC_RAW_8)
                | (cfg.mode == VPC_YC_8) | m_ts;
    // Channel B only beside narrow BT.656 or raw A
    assign b_en = cfg.dual & (m_bt | m_rawn);
    // Each channel uses its own pin clock
    assign edge_s[0] = capture_enable & lclk_f[0] & ~lclk_prev_q[0];
    assign edge_s[1] = capture_enable & b_en & lclk_f[1] & ~lclk_prev_q[1];
    assign ch_bt[0] = m_bt;
    assign ch_bt[1] = b_en & ~cfg.chb_raw;
    assign ch_raw[0] = m_rawn;
    assign ch_raw[1] = b_en & cfg.chb_raw;
    assign yc_on[0] = m_yc;
    assign yc_on[1] = 1'b0;
    // A on the low half; B or Y/C chroma on the high half
    assign samp[0] = bus_f[9:0];
    assign samp[1] = bus_f[19:10];

    // Filters only for 8-bit components
    always_ff @(posedge clk) begin
        if (clr) begin
            resample_active <= 1'b0;
            scale_active <= 1'b0;
        end else begin
            resample_active <= cfg.resample_req & (m_bt | m_yc)
                & m_8b;
            scale_active <= cfg.scale_req & (m_bt | m_yc)
                & m_8b;
        end
    end

    // Pushes into the packers
    logic [VPC_NUM_FIFO-1:0] push_v;
    logic [VPC_NUM_FIFO-1:0][VPC_BUS_W-1:0] push_s;
    logic [1:0] ext_v;
    logic [1:0][VPC_BUS_W-1:0] ext_s;
    logic ts_push;
    logic [7:0] ts_byte;

    // Channel A also carries wide raw and transport words
    assign ext_v[0] = (edge_s[0] & m_wide) | ts_push;
    assign ext_v[1] = 1'b0;
    assign ext_s[0] = ts_push ? {12'h000, ts_byte} : bus_f;
    assign ext_s[1] = '0;

    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        logic [7:0] h1_q;
        logic [7:0] h2_q;
        logic [7:0] h3_q;
        logic [VPC_POS_W-1:0] pos_q;
        logic [1:0] phase_q;
        logic field_q;
        logic seen_q;
        logic started_q;
        logic done_q;
        logic la_prev_q;
        logic use_ctl;
        logic code_hit;
        logic sav_ev;
        logic eav_ev;
        logic field_new;
        logic fld_chg;
        logic win_ok;
        logic fld_ok;
        logic cap;
        logic bt_cap;
        logic yc_cap;

        // Control pins feed only channel A Y/C sync
        assign use_ctl = yc_on[ch] & cfg.yc_ctl_sync;
        assign code_hit = edge_s[ch] & (h3_q == VPC_CODE_FF)
                        & (h2_q == VPC_CODE_00) & (h1_q == VPC_CODE_00);
        assign sav_ev = use_ctl ? (ctl_la & ~la_prev_q)
                                : (code_hit & ~samp[ch][VPC_XY_H]);
        assign eav_ev = use_ctl ? (~ctl_la & la_prev_q)
                                : (code_hit & samp[ch][VPC_XY_H]);
        assign field_new = use_ctl ? ctl_fld : samp[ch][VPC_XY_F];
        assign fld_chg = sav_ev & seen_q & (field_new != field_q);
        // Counts from EAV, so the window may open on ancillary data
        assign win_ok = (pos_q >= cfg.win_start) & (pos_q <= cfg.win_stop);
        assign fld_ok = (cfg.fsel == VPC_FSEL_ALL)
                      | ((cfg.fsel == VPC_FSEL_ODD) & ~field_q)
                      | ((cfg.fsel == VPC_FSEL_EVEN) & field_q)
                      | ((cfg.fsel == VPC_FSEL_SINGLE) & started_q & ~done_q);
        assign cap = edge_s[ch] & win_ok & fld_ok;
        assign bt_cap = ch_bt[ch] & cap;
        assign yc_cap = yc_on[ch] & cap;

        // 8-bit components keep the upper eight bits
        assign comp[ch] = m_8b ? {12'h000, samp[ch][9:2]} : {10'h000, samp[ch]};
        assign rawv[ch] = m_8b ? {12'h000, samp[ch][7:0]} : {10'h000, samp[ch]};

        // Phase 0 Cb, 1 Y, 2 Cr, 3 Y; Y/C chroma is Cb then Cr
        assign push_v[ch*3] = (bt_cap & phase_q[0]) | yc_cap
                            | (edge_s[ch] & ch_raw[ch]) | ext_v[ch];
        assign push_v[ch*3+1] = (bt_cap & (phase_q == 2'h0))
                              | (yc_cap & ~phase_q[0]);
        assign push_v[ch*3+2] = (bt_cap & (phase_q == 2'h2))
                              | (yc_cap & phase_q[0]);
        assign push_s[ch*3] = ext_v[ch] ? ext_s[ch] : (ch_raw[ch] ? rawv[ch] : comp[ch]);
        assign push_s[ch*3+1] = yc_on[ch] ? comp[1] : comp[ch];
        assign push_s[ch*3+2] = yc_on[ch] ? comp[1] : comp[ch];
        assign field_done[ch] = done_q;

        always_ff @(posedge clk) begin
            if (clr) begin
                h1_q <= 8'h00;
                h2_q <= 8'h00;
                h3_q <= 8'h00;
                pos_q <= VPC_POS_RST;
                phase_q <= 2'h0;
                field_q <= 1'b0;
                seen_q <= 1'b0;
                started_q <= 1'b0;
                done_q <= 1'b0;
                la_prev_q <= 1'b0;
            end else begin
                if (edge_s[ch]) begin
                    h1_q <= samp[ch][9:2];
                    h2_q <= h1_q;
                    h3_q <= h2_q;
                end
                la_prev_q <= ctl_la;
                if (eav_ev) begin
                    pos_q <= VPC_POS_RST;
                end else if (edge_s[ch] && pos_q != '1) begin
                    pos_q <= pos_q + 12'h001;
                end
                if (sav_ev) begin
                    phase_q <= 2'h0;
                end else if (edge_s[ch]) begin
                    phase_q <= phase_q + 2'h1;
                end
                if (sav_ev) begin
                    field_q <= field_new;
                    seen_q <= 1'b1;
                end
                // Single capture spans one field change to the next
                if (fld_chg && !started_q) begin
                    started_q <= 1'b1;
                end else if (fld_chg) begin
                    done_q <= 1'b1;
                end
            end
        end
    end

    // Transport receiver on channel A
    vpc_ts_state_t ts_st_q;
    logic [VPC_POS_W-1:0] bcnt_q;
    logic [7:0] pend_q;
    logic [7:0] late_byte_q;
    logic late_q;
    logic drop_q;
    logic ts_edge;
    logic ts_err;
    logic ts_end;
    logic [VPC_TIME_W-1:0] systime_q;

    assign ts_edge = edge_s[0] & m_ts;
    assign ts_byte = late_q ? late_byte_q
                   : (ts_st_q == VPC_TS_HDR1) ? pend_q : samp[0][7:0];
    assign ts_err = cfg.ts_drop_err & samp[0][VPC_TS_ERR_BIT];
    assign ts_end = (bcnt_q + 12'h001 >= cfg.ts_pkt_len) & (bcnt_q >= VPC_TS_HDR_LEN - 12'h001);
    // Header byte 1 goes in a cycle after the held sync
    assign ts_push = late_q | (ts_edge & (ts_st_q == VPC_TS_HDR1) & ~ts_err)
                   | (ts_edge & (ts_st_q == VPC_TS_BODY) & ~drop_q);
    assign ts_locked = (ts_st_q != VPC_TS_HUNT);

    always_ff @(posedge clk) begin
        if (clr) begin
            ts_st_q <= VPC_TS_HUNT;
            bcnt_q <= VPC_POS_RST;
            pend_q <= 8'h00;
            late_byte_q <= 8'h00;
            late_q <= 1'b0;
            drop_q <= 1'b0;
            ts_stamp <= VPC_TIME_RST;
            ts_stamp_valid <= 1'b0;
            ts_dropped <= 1'b0;
        end else begin
            late_q <= 1'b0;
            ts_stamp_valid <= 1'b0;
            ts_dropped <= 1'b0;
            if (ts_edge) begin
                unique case (ts_st_q)
                    VPC_TS_HUNT: begin
                        if (samp[0][7:0] == VPC_TS_SYNC) begin
                            pend_q <= samp[0][7:0];
                            bcnt_q <= 12'h001;
                            ts_stamp <= systime_q;
                            ts_stamp_valid <= 1'b1;
                            ts_st_q <= VPC_TS_HDR1;
                        end
                    end
                    VPC_TS_HDR1: begin
                        bcnt_q <= 12'h002;
                        drop_q <= ts_err;
                        ts_dropped <= ts_err;
                        late_q <= ~ts_err;
                        late_byte_q <= samp[0][7:0];
                        ts_st_q <= VPC_TS_BODY;
                    end
                    VPC_TS_BODY: begin
                        bcnt_q <= bcnt_q + 12'h001;
                        if (ts_end) begin
                            ts_st_q <= VPC_TS_HUNT;
                            drop_q <= 1'b0;
                        end
                    end
                endcase
            end
        end
    end

    // System time and time events
    logic [VPC_TIME_W-1:0] intv_q;
    logic abs_hit;
    logic intv_hit;

    assign abs_hit = tmr.abs_en & (systime_q == tmr.abs_time);
    assign intv_hit = tmr.intv_en & (intv_q + 32'h0000_0001 >= tmr.intv);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            systime_q <= VPC_TIME_RST;
        end else begin
            systime_q <= systime_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk) begin
        if (clr) begin
            intv_q <= VPC_TIME_RST;
            time_event <= 1'b0;
        end else begin
            intv_q <= (intv_hit || !tmr.intv_en) ? VPC_TIME_RST : intv_q + 32'h0000_0001;
            time_event <= abs_hit | intv_hit;
        end
    end

    // Packers and FIFOs
    logic [VPC_NUM_FIFO-1:0] fifo_in_ready;
    for (genvar k = 0; k < VPC_NUM_FIFO; k++) begin : g_fifo
        logic [VPC_FIFO_W-1:0] acc_q;
        logic [VPC_FIFO_W-1:0] acc_d;
        logic [VPC_FIFO_W-1:0] out_q;
        logic [1:0] cnt_q;
        logic [1:0] last;
        logic pend_w_q;
        logic word_done;
        logic load;
        logic [VPC_LVL_W-1:0] level;

        // Little endian: first sample in the low lane
        assign acc_d = m_wide ? {12'h000, push_s[k]}
            : m_8b ? (cfg.big_endian ? {acc_q[23:0], push_s[k][7:0]}
                                     : {push_s[k][7:0], acc_q[31:8]})
            : (cfg.big_endian ? {acc_q[15:0], push_s[k][15:0]}
                              : {push_s[k][15:0], acc_q[31:16]});
        assign last = m_wide ? 2'h0 : (m_8b ? 2'h3 : 2'h1);
        assign word_done = push_v[k] & (cnt_q == last);
        assign load = word_done & (~pend_w_q | fifo_in_ready[k]);

        always_ff @(posedge clk) begin
            if (clr) begin
                acc_q <= VPC_WORD_RST;
                out_q <= VPC_WORD_RST;
                cnt_q <= 2'h0;
                pend_w_q <= 1'b0;
                overflow[k] <= 1'b0;
                dma_req[k] <= 1'b0;
            end else begin
                if (push_v[k]) begin
                    acc_q <= acc_d;
                    cnt_q <= word_done ? 2'h0 : cnt_q + 2'h1;
                end
                if (load) begin
                    out_q <= acc_d;
                    pend_w_q <= 1'b1;
                end else if (fifo_in_ready[k]) begin
                    pend_w_q <= 1'b0;
                end
                // Pins cannot stall, so a blocked word is lost
                if (word_done && !load) begin
                    overflow[k] <= 1'b1;
                end
                dma_req[k] <= (cfg.dma_thresh != '0) & (level >= cfg.dma_thresh);
            end
        end

        vpc_fifo #(.W(VPC_FIFO_W), .DEPTH(VPC_FIFO_DEPTH)) u_fifo (
            .clk(clk),
            .resetn(resetn),
            .flush(~capture_enable),
            .in_valid(pend_w_q),
            .in_ready(fifo_in_ready[k]),
            .in_data(out_q),
            .out_valid(rd_valid[k]),
            .out_ready(rd_ready[k]),
            .out_data(rd_data[k]),
            .level(level)
        );
    end
endmodule

`default_nettype wire

// ===== testbench/vpc_capture_port_sva.sv
/* Port checker for vpc_capture_port.
   Assumes a bind; cfg moves only while capture is off. */
`default_nettype none
module vpc_capture_port_sva (
    // Clock, reset, controls
    input wire logic clk,
    input wire logic resetn,
    input wire logic capture_enable,
    input wire vpc_pkg::vpc_cfg_t cfg,
    input wire vpc_pkg::vpc_timer_cfg_t tmr,
    // Outputs watched
    input wire logic [5:0] rd_valid,
    input wire logic [5:0] dma_req,
    input wire logic [1:0] field_done,
    input wire logic resample_active,
    input wire logic scale_active,
    input wire logic ts_locked,
    input wire logic ts_stamp_valid,
    input wire logic ts_dropped,
    input wire logic time_event
);
    import vpc_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    rst_quiet_a: assert property (
        $rose(resetn) |-> rd_valid == 6'h00 && dma_req == 6'h00) else $error("busy after reset");
    dis_flush_a: assert property (
        !capture_enable |=> rd_valid == 6'h00 && dma_req == 6'h00 && !ts_locked)
        else $error("kept while off");
    dma_thr_a: assert property (
        dma_req != 6'h00 |-> $past(cfg.dma_thresh) != 6'h00) else $error("dma, zero threshold");
    filt_ok_a: assert property (
        resample_active || scale_active |-> $past(cfg.mode) inside {VPC_BT656_8, VPC_YC_8})
        else $error("filter in wrong mode");
    ts_lock_a: assert property (
        ts_locked |-> cfg.mode == VPC_TS_8) else $error("lock outside mode");
    stamp_pulse_a: assert property (
        ts_stamp_valid |=> !ts_stamp_valid) else $error("stamp too long");
    drop_ctl_a: assert property (
        ts_dropped |-> $past(cfg.ts_drop_err)) else $error("drop, discard off");
    chb_dual_a: assert property (
        rd_valid[5:3] != 3'h0 || field_done[1] |-> cfg.dual) else $error("channel B active");
    evt_src_a: assert property (
        time_event |-> $past(tmr.abs_en || tmr.intv_en)) else $error("time event unarmed");
endmodule
`default_nettype wire

// ===== testbench/vpc_pixel_source.sv
/* Pixel source: one sample per 160 ns pin clock, either channel.
   Assumes 50 MHz clk; pin clocks idle low. */
`default_nettype none
module vpc_pixel_source (
    // System clock
    input wire logic clk,
    // Pins
    output logic clk_a,
    output logic clk_b,
    output logic [19:0] bus
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        clk_a = 1'b0;
        clk_b = 1'b0;
        bus = 20'h00000;
    end
    // Idle data is inverted so a late sample shows up
    task send(input logic ch_b, input logic [19:0] w);
        @(posedge clk) bus <= w;
        repeat (3) @(posedge clk);
        if (ch_b) clk_b <= 1'b1; else clk_a <= 1'b1;
        repeat (4) @(posedge clk);
        clk_a <= 1'b0;
        clk_b <= 1'b0;
        bus <= ~w;
    endtask
endmodule
`default_nettype wire

// ===== testbench/vpc_capture_port_bench.sv
/* Bench for vpc_capture_port: raw, dual, TS and BT.656 capture.
   Assumes package, design and helpers compiled first. */
`default_nettype none
module vpc_capture_port_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import vpc_pkg::*;
    logic clk, resetn, capture_enable, ctl_line_active, ctl_field, clk_a, clk_b;
    logic [19:0] pix;
    vpc_cfg_t cfg, c;
    vpc_timer_cfg_t tmr;
    logic [5:0] rd_valid, rd_ready, dma_req, overflow;
    logic [5:0][31:0] rd_data;
    logic [1:0] field_done;
    logic resample_active, scale_active, ts_locked, ts_stamp_valid, ts_dropped, time_event;
    logic [31:0] ts_stamp;
    int n_fail, tests_run, cyc, n_stamp, n_drop, n_evt;
    vpc_capture_port dut_u (.clk, .resetn, .chan_a_capture_clock(clk_a),
        .chan_b_capture_clock(clk_b), .port_pixel_bus(pix), .ctl_line_active, .ctl_field,
        .capture_enable, .cfg, .tmr, .rd_valid, .rd_ready, .rd_data, .dma_req, .overflow,
        .field_done, .resample_active, .scale_active, .ts_locked, .ts_stamp,
        .ts_stamp_valid, .ts_dropped, .time_event);
    vpc_pixel_source src_u (.clk, .clk_a, .clk_b, .bus(pix));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task complete_run;
        $display("checks %0d fails %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask
    // Config moves only while capture is off
    task setup(input vpc_cfg_t v);
        @(posedge clk) capture_enable <= 1'b0;
        @(posedge clk) cfg <= v;
        repeat (2) @(posedge clk);
        capture_enable <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    task bytes(input logic b, input logic [31:0] w, input int sh);
        for (int i = 0; i < 4; i++) src_u.send(b, 20'(w[8*i +: 8]) << sh);
    endtask
    task bt(input logic [7:0] v);
        src_u.send(1'b0, {10'h000, v, 2'b11});
    endtask
    task pop(input int k, input logic [31:0] e);
        @(negedge clk);
        for (int t = 0; t < 80 && rd_valid[k] !== 1'b1; t++) @(negedge clk);
        chk("rd_valid", 32'h1, {31'h0, rd_valid[k]});
        chk("rd_data", e, rd_data[k]);
        @(negedge clk);
        chk("dma_req", 32'h1, {31'h0, dma_req[k]});
        @(posedge clk) rd_ready[k] <= 1'b1;
        @(posedge clk) rd_ready[k] <= 1'b0;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (ts_stamp_valid === 1'b1) n_stamp++;
        if (ts_dropped === 1'b1) n_drop++;
        if (time_event === 1'b1) n_evt++;
        if (cyc == 20000) begin
            n_fail++;
            complete_run;
        end
    end
    initial begin
        {resetn, capture_enable, ctl_line_active, ctl_field, rd_ready} = '0;
        cfg = '0;
        tmr = '0;
        tmr.intv_en = 1'b1;
        tmr.intv = 32'h64;
        c = '0;
        c.dma_thresh = 6'h01;
        c.win_start = 12'h004;
        c.win_stop = 12'h013;
        c.ts_pkt_len = 12'h004;
        c.resample_req = 1'b1;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk) chk("rd_valid", 32'h0, {26'h0, rd_valid});
        repeat (6) @(posedge clk);
        c.mode = VPC_RAW_8;
        setup(c);
        bytes(1'b0, 32'h4433_2211, 0);
        pop(0, 32'h4433_2211);
        chk("resample", 32'h0, {31'h0, resample_active});
        c.big_endian = 1'b1;
        setup(c);
        bytes(1'b0, 32'h4433_2211, 0);
        pop(0, 32'h1122_3344);
        c.big_endian = 1'b0;
        $display("raw8 done");
        c.mode = VPC_RAW_20;
        setup(c);
        src_u.send(1'b0, 20'hABCDE);
        pop(0, 32'h000A_BCDE);
        c.mode = VPC_RAW_8;
        setup(c);
        bytes(1'b1, 32'h8877_6655, 10);
        bytes(1'b0, 32'h0403_0201, 0);
        pop(0, 32'h0403_0201);
        chk("rd_valid_b", 32'h0, {31'h0, rd_valid[3]});
        c.dual = 1'b1;
        c.chb_raw = 1'b1;
        setup(c);
        bytes(1'b1, 32'h8877_6655, 10);
        pop(3, 32'h8877_6655);
        c.dual = 1'b0;
        $display("raw done");
        c.mode = VPC_TS_8;
        setup(c);
        bytes(1'b0, 32'h0302_0147, 0);
        pop(0, 32'h0302_0147);
        chk("stamps", 32'h1, 32'(n_stamp));
        c.ts_drop_err = 1'b1;
        setup(c);
        bytes(1'b0, 32'h0000_8047, 0);
        repeat (20) @(negedge clk);
        chk("drops", 32'h1, 32'(n_drop));
        chk("rd_valid", 32'h0, {31'h0, rd_valid[0]});
        c.ts_drop_err = 1'b0;
        $display("ts done");
        c.mode = VPC_BT656_8;
        setup(c);
        for (int i = 0; i < 8; i++) bt(i % 4 == 0 ? 8'hFF : (i == 3 ? 8'h10 : 8'h00));
        for (int i = 0; i < 4; i++) begin
            bt(8'hC0 + 8'(i));
            bt(8'h10 + 8'(2 * i));
            bt(8'hE0 + 8'(i));
            bt(8'h11 + 8'(2 * i));
        end
        pop(1, 32'hC3C2_C1C0);
        pop(2, 32'hE3E2_E1E0);
        pop(0, 32'h1312_1110);
        pop(0, 32'h1716_1514);
        chk("resample", 32'h1, {31'h0, resample_active});
        $display("bt656 done");
        chk("time_event", 32'h1, {31'h0, n_evt > 0});
        $display("timer done");
        complete_run;
    end
endmodule
bind vpc_capture_port vpc_capture_port_sva chk_u (.clk, .resetn, .capture_enable, .cfg,
    .tmr, .rd_valid, .dma_req, .field_done, .resample_active, .scale_active, .ts_locked,
    .ts_stamp_valid, .ts_dropped, .time_event);
`default_nettype wire
